// ==== design/rpr_pkg.sv ====
/*
  Package for the reader PLL / DAC / ADC / RX length register bank: register offsets,
  field positions, preset values, direct command codes and timing constants.
  Assumes a single 100 MHz core clock; the host reaches the bank through a plain register
  port and a direct command strobe decoded elsewhere from the parallel or serial interface.
*/
package rpr_pkg;

  // register offsets on the host register port
  localparam logic [5:0] ADDR_PLL_MAIN   = 6'h16;
  localparam logic [5:0] ADDR_PLL_AUX    = 6'h17;
  localparam logic [5:0] ADDR_DAC        = 6'h18;
  localparam logic [5:0] ADDR_ADC_RESULT = 6'h19;
  localparam logic [5:0] ADDR_RX_LEN_HI  = 6'h1A;
  localparam logic [5:0] ADDR_RX_LEN_LO  = 6'h1B;

  // preset values
  localparam logic [23:0] RST_PLL_MAIN   = 24'h40D84F;
  localparam logic [23:0] RST_PLL_AUX    = 24'h011846;
  localparam logic [7:0]  RST_DAC        = 8'h00;
  localparam logic [7:0]  RST_ADC_RESULT = 8'h00;
  localparam logic [7:0]  RST_RX_LEN     = 8'h00;

  // field positions inside the PLL divider words
  localparam int PLL_BIAS_BIT    = 23;
  localparam int PLL_REF_MSB     = 22;
  localparam int PLL_REF_LSB     = 20;
  localparam int PLL_VCO_DIR_BIT = 22;
  localparam int PLL_EXT_RF_BIT  = 21;
  localparam int PLL_PRESC_BIT   = 20;
  localparam int PLL_B_MSB       = 19;
  localparam int PLL_B_LSB       = 10;
  localparam int PLL_A_MSB       = 9;
  localparam int PLL_A_LSB       = 0;

  // field positions inside the first RX length register
  localparam int RX_SKIP_CRC_BIT = 7;
  localparam int RX_RAW_FIFO_BIT = 6;
  localparam int RX_LEN_HI_MSB   = 1;

  // reference divider codes
  localparam logic [2:0] REF_500K = 3'h0;
  localparam logic [2:0] REF_250K = 3'h1;
  localparam logic [2:0] REF_125K = 3'h2;
  localparam logic [2:0] REF_200K = 3'h4;
  localparam logic [2:0] REF_100K = 3'h5;
  localparam logic [2:0] REF_50K  = 3'h6;
  localparam logic [2:0] REF_25K  = 3'h7;

  // direct command codes handled here
  localparam logic [7:0] CMD_SOFT_INIT = 8'h83;
  localparam logic [7:0] CMD_HOP_MAIN  = 8'h84;
  localparam logic [7:0] CMD_HOP_AUX   = 8'h85;
  localparam logic [7:0] CMD_ADC_TRIG  = 8'h87;

  // timing: a longest time rounds down to whole cycles
  localparam int CLK_PERIOD_NS    = 10;
  localparam int ADC_CONV_TIME_NS = 20000;
  localparam int ADC_CONV_CYCLES  = ADC_CONV_TIME_NS / CLK_PERIOD_NS;

  // adc sequencer states, gray coded along idle -> convert -> done
  typedef enum logic [1:0] {
    ADC_IDLE = 2'b00,
    ADC_CONV = 2'b01,
    ADC_DONE = 2'b11
  } rpr_adc_state_t;

endpackage : rpr_pkg

// ==== design/rpr_adc_seq.sv ====
/*
  ADC conversion sequencer: starts the converter, waits the conversion time and holds the
  last result in a register. Assumes the converter output is valid by the capture cycle
  and that the trigger is a one-cycle pulse in the core clock domain.
*/
module rpr_adc_seq
  import rpr_pkg::*;
#(
  parameter int CONV_CYCLES = ADC_CONV_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       preset_i,
  input  wire logic       trig_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] result_o,
  output logic            busy_o,
  output logic            start_o
);

  logic [15:0]    cnt;
  rpr_adc_state_t state;
  rpr_adc_state_t next_state;
  logic [15:0]    next_cnt;
  wire            last_cyc = (cnt == 16'(CONV_CYCLES - 2));

  // next state; a new trigger restarts a running conversion
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      ADC_IDLE: begin
        if (trig_i) begin
          next_state = ADC_CONV;
          next_cnt   = 16'h0000;
        end
      end
      ADC_CONV: begin
        next_cnt = cnt + 16'h0001;
        if (trig_i) begin
          next_cnt = 16'h0000;
        end else if (last_cyc) begin
          next_state = ADC_DONE;
        end
      end
      ADC_DONE: begin
        next_state = trig_i ? ADC_CONV : ADC_IDLE;
        next_cnt   = 16'h0000;
      end
      default: begin
        next_state = ADC_IDLE;
      end
    endcase
  end

  // state and counter; chip disable aborts a conversion
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ADC_IDLE;
      cnt   <= 16'h0000;
    end else if (preset_i) begin
      state <= ADC_IDLE;
      cnt   <= 16'h0000;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // result held until the next conversion completes, so a late read still sees old data
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      result_o <= RST_ADC_RESULT;
    end else if (state == ADC_CONV && last_cyc && !trig_i && !preset_i) begin
      result_o <= data_i;
    end
  end

  // status strobes toward the converter
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_o  <= 1'b0;
      start_o <= 1'b0;
    end else begin
      busy_o  <= !preset_i && (next_state == ADC_CONV);
      start_o <= !preset_i && trig_i;
    end
  end

endmodule : rpr_adc_seq

// ==== design/rpr_regs.sv ====
/*
  Register bank for the reader synthesizer dividers, PA bias options, DAC setting, ADC
  readout and expected receive length, plus the direct commands that retune the
  synthesizer and start an ADC conversion. Assumes the host interface has already turned
  parallel or serial transfers into single-cycle register and command strobes in the
  core clock domain, and that the receiver pulses the end of each reception.
*/

// Functional notes
// - reference code selects 500/250/200/125/100/50/25 kHz PLL reference
// - B in 19:10, A in 9:0, division N = 32*B + 33*A
// - bit 23 doubles PA bias in main word, quadruples it in aux word
// - aux bit 22 chooses normal or direct VCO connection
// - aux bit 21 chooses internal VCO or external RF input pin
// - aux bit 20 enables divider and prescaler for an external VCO
// - main divider presets to 40D84F on reset or chip disable
// - aux divider presets to 011846 on reset or chip disable
// - DAC setting clears to zero on reset or chip disable
// - three-bit measurement select picks the ADC input source
// - command 87 starts conversion; result valid within 20 us
// - skip-CRC bit applies to the next reception only
// - raw FIFO mode stores CRC bytes, header irq becomes second-byte irq
// - raw FIFO mode turns third error irq into reception-finished irq
// - ten-bit receive length split across the two RX length registers
// - both RX length registers clear on reset, chip disable, reception end
// - command 84 retunes from main divider, 85 from aux divider
module rpr_regs
  import rpr_pkg::*;
#(
  parameter int CONV_CYCLES = ADC_CONV_CYCLES
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        EN_I,
  input  wire logic [5:0]  REG_ADDR_I,
  input  wire logic [23:0] REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic      [23:0] REG_RDATA_O,
  output logic             REG_RVALID_O,
  input  wire logic [7:0]  CMD_I,
  input  wire logic        CMD_STB_I,
  input  wire logic [2:0]  ADC_MSEL_I,
  input  wire logic [7:0]  ADC_DATA_I,
  output logic      [2:0]  ADC_MSEL_O,
  output logic             ADC_START_O,
  output logic             ADC_BUSY_O,
  input  wire logic        RX_START_I,
  input  wire logic        RX_END_I,
  output logic             RX_SKIP_CRC_O,
  output logic             RX_RAW_FIFO_O,
  output logic             IRQ_HDR_IS_2ND_BYTE_O,
  output logic             THIRD_ERROR_IRQ_IS_RX_DONE_O,
  output logic      [9:0]  RX_LEN_O,
  output logic      [2:0]  PLL_REF_SELECT_O,
  output logic      [9:0]  PLL_REF_KHZ_O,
  output logic      [9:0]  SYNTH_B_O,
  output logic      [9:0]  SYNTH_A_O,
  output logic      [16:0] SYNTH_N_O,
  output logic             SYNTH_LOAD_O,
  output logic             PA_BIAS_DOUBLE_O,
  output logic             PA_BIAS_QUAD_O,
  output logic             VCO_DIRECT_O,
  output logic             EXT_RF_SELECT_O,
  output logic             PRESC_EN_O,
  output logic      [7:0]  DAC_VALUE_O
);

  // stored registers
  logic [23:0] pll_main_divider;
  logic [23:0] pll_aux_divider;
  logic [7:0]  dac_setting;
  logic [7:0]  rx_length_high;
  logic [7:0]  rx_length_low;
  logic [7:0]  adc_result;
  logic        rx_active;

  // direct command decode
  wire cmd_soft_init = CMD_STB_I && (CMD_I == CMD_SOFT_INIT);
  wire cmd_hop_main  = CMD_STB_I && (CMD_I == CMD_HOP_MAIN);
  wire cmd_hop_aux   = CMD_STB_I && (CMD_I == CMD_HOP_AUX);
  wire cmd_adc_trig  = CMD_STB_I && (CMD_I == CMD_ADC_TRIG);

  // chip disable and soft init both act as a synchronous preset
  wire preset = !EN_I || cmd_soft_init;

  // register write decode; the ADC result offset has no write strobe at all
  wire wr_main   = REG_WR_I && (REG_ADDR_I == ADDR_PLL_MAIN);
  wire wr_aux    = REG_WR_I && (REG_ADDR_I == ADDR_PLL_AUX);
  wire wr_dac    = REG_WR_I && (REG_ADDR_I == ADDR_DAC);
  wire wr_rx_hi  = REG_WR_I && (REG_ADDR_I == ADDR_RX_LEN_HI);
  wire wr_rx_lo  = REG_WR_I && (REG_ADDR_I == ADDR_RX_LEN_LO);

  // only the used bits of the first RX length register are stored; bits 5:2 read zero
  wire [7:0] rx_hi_mask  = 8'hC3;
  wire [7:0] rx_hi_wdata = REG_WDATA_I[7:0] & rx_hi_mask;

  // read multiplexer, unmapped offsets read zero
  wire [23:0] rd_mux =
    (REG_ADDR_I == ADDR_PLL_MAIN)   ? pll_main_divider :
    (REG_ADDR_I == ADDR_PLL_AUX)    ? pll_aux_divider :
    (REG_ADDR_I == ADDR_DAC)        ? {16'h0000, dac_setting} :
    (REG_ADDR_I == ADDR_ADC_RESULT) ? {16'h0000, adc_result} :
    (REG_ADDR_I == ADDR_RX_LEN_HI)  ? {16'h0000, rx_length_high} :
    (REG_ADDR_I == ADDR_RX_LEN_LO)  ? {16'h0000, rx_length_low} :
                                      24'h000000;

  // field views of the divider words
  wire [2:0] main_ref = pll_main_divider[PLL_REF_MSB:PLL_REF_LSB];
  wire [9:0] main_b   = pll_main_divider[PLL_B_MSB:PLL_B_LSB];
  wire [9:0] main_a   = pll_main_divider[PLL_A_MSB:PLL_A_LSB];
  wire [9:0] aux_b    = pll_aux_divider[PLL_B_MSB:PLL_B_LSB];
  wire [9:0] aux_a    = pll_aux_divider[PLL_A_MSB:PLL_A_LSB];

  // divider picked by a hop command; a write without a hop does not retune
  wire [9:0] hop_b = cmd_hop_aux ? aux_b : main_b;
  wire [9:0] hop_a = cmd_hop_aux ? aux_a : main_a;
  wire       hop   = cmd_hop_main || cmd_hop_aux;

  // total division through the 32/33 prescaler
  wire [16:0] hop_n = {2'b00, hop_b, 5'b00000} + {2'b00, hop_a, 5'b00000}
                    + {7'h00, hop_a};

  // reference frequency in kHz per divider code; code 3 is not defined and reads zero
  function automatic logic [9:0] ref_khz(input logic [2:0] code);
    logic [9:0] khz;
    khz = 10'h000;
    case (code)
      REF_500K: khz = 10'h1F4;
      REF_250K: khz = 10'h0FA;
      REF_200K: khz = 10'h0C8;
      REF_125K: khz = 10'h07D;
      REF_100K: khz = 10'h064;
      REF_50K:  khz = 10'h032;
      REF_25K:  khz = 10'h019;
      default:  khz = 10'h000;
    endcase
    return khz;
  endfunction : ref_khz

  // main divider word
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pll_main_divider <= RST_PLL_MAIN;
    end else if (preset) begin
      pll_main_divider <= RST_PLL_MAIN;
    end else if (wr_main) begin
      pll_main_divider <= REG_WDATA_I;
    end
  end

  // auxiliary divider word
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pll_aux_divider <= RST_PLL_AUX;
    end else if (preset) begin
      pll_aux_divider <= RST_PLL_AUX;
    end else if (wr_aux) begin
      pll_aux_divider <= REG_WDATA_I;
    end
  end

  // DAC setting
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      dac_setting <= RST_DAC;
    end else if (preset) begin
      dac_setting <= RST_DAC;
    end else if (wr_dac) begin
      dac_setting <= REG_WDATA_I[7:0];
    end
  end

  // first RX length register: one-shot options and length bits 9:8;
  // a host write in the end-of-reception cycle wins, so a setting for the next frame is kept
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rx_length_high <= RST_RX_LEN;
    end else if (preset) begin
      rx_length_high <= RST_RX_LEN;
    end else if (wr_rx_hi) begin
      rx_length_high <= rx_hi_wdata;
    end else if (RX_END_I) begin
      rx_length_high <= RST_RX_LEN;
    end
  end

  // second RX length register: length bits 7:0
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rx_length_low <= RST_RX_LEN;
    end else if (preset) begin
      rx_length_low <= RST_RX_LEN;
    end else if (wr_rx_lo) begin
      rx_length_low <= REG_WDATA_I[7:0];
    end else if (RX_END_I) begin
      rx_length_low <= RST_RX_LEN;
    end
  end

  // reception in progress, used only to freeze the options seen by the receiver
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rx_active <= 1'b0;
    end else if (preset || RX_END_I) begin
      rx_active <= 1'b0;
    end else if (RX_START_I) begin
      rx_active <= 1'b1;
    end
  end

  // receive options toward the framer; frozen during a frame so a mid-frame write cannot
  // change how the running reception is checked or where its interrupts go
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RX_SKIP_CRC_O         <= 1'b0;
      RX_RAW_FIFO_O         <= 1'b0;
      IRQ_HDR_IS_2ND_BYTE_O <= 1'b0;
      THIRD_ERROR_IRQ_IS_RX_DONE_O <= 1'b0;
      RX_LEN_O              <= 10'h000;
    end else if (preset) begin
      RX_SKIP_CRC_O         <= 1'b0;
      RX_RAW_FIFO_O         <= 1'b0;
      IRQ_HDR_IS_2ND_BYTE_O <= 1'b0;
      THIRD_ERROR_IRQ_IS_RX_DONE_O <= 1'b0;
      RX_LEN_O              <= 10'h000;
    end else if (!rx_active || RX_END_I) begin
      RX_SKIP_CRC_O         <= rx_length_high[RX_SKIP_CRC_BIT];
      RX_RAW_FIFO_O         <= rx_length_high[RX_RAW_FIFO_BIT];
      IRQ_HDR_IS_2ND_BYTE_O <= rx_length_high[RX_RAW_FIFO_BIT];
      THIRD_ERROR_IRQ_IS_RX_DONE_O <= rx_length_high[RX_RAW_FIFO_BIT];
      RX_LEN_O              <= {rx_length_high[RX_LEN_HI_MSB:0], rx_length_low};
    end
  end

  // synthesizer divider loaded only by a hop command
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      SYNTH_B_O    <= RST_PLL_MAIN[PLL_B_MSB:PLL_B_LSB];
      SYNTH_A_O    <= RST_PLL_MAIN[PLL_A_MSB:PLL_A_LSB];
      SYNTH_N_O    <= 17'h010EF;
      SYNTH_LOAD_O <= 1'b0;
    end else begin
      SYNTH_LOAD_O <= hop && !preset;
      if (hop && !preset) begin
        SYNTH_B_O <= hop_b;
        SYNTH_A_O <= hop_a;
        SYNTH_N_O <= hop_n;
      end
    end
  end

  // static analog options follow the registers directly
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PLL_REF_SELECT_O <= RST_PLL_MAIN[PLL_REF_MSB:PLL_REF_LSB];
      PLL_REF_KHZ_O    <= 10'h0C8;
      PA_BIAS_DOUBLE_O <= RST_PLL_MAIN[PLL_BIAS_BIT];
      PA_BIAS_QUAD_O   <= RST_PLL_AUX[PLL_BIAS_BIT];
      VCO_DIRECT_O     <= RST_PLL_AUX[PLL_VCO_DIR_BIT];
      EXT_RF_SELECT_O  <= RST_PLL_AUX[PLL_EXT_RF_BIT];
      PRESC_EN_O       <= RST_PLL_AUX[PLL_PRESC_BIT];
      DAC_VALUE_O      <= RST_DAC;
    end else begin
      PLL_REF_SELECT_O <= main_ref;
      PLL_REF_KHZ_O    <= ref_khz(main_ref);
      PA_BIAS_DOUBLE_O <= pll_main_divider[PLL_BIAS_BIT];
      PA_BIAS_QUAD_O   <= pll_aux_divider[PLL_BIAS_BIT];
      VCO_DIRECT_O     <= pll_aux_divider[PLL_VCO_DIR_BIT];
      EXT_RF_SELECT_O  <= pll_aux_divider[PLL_EXT_RF_BIT];
      PRESC_EN_O       <= pll_aux_divider[PLL_PRESC_BIT];
      DAC_VALUE_O      <= dac_setting;
    end
  end

  // measurement source latched at trigger, so changing it mid-conversion is harmless
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ADC_MSEL_O <= 3'h0;
    end else if (cmd_adc_trig && !preset) begin
      ADC_MSEL_O <= ADC_MSEL_I;
    end
  end

  // conversion sequencer and result holding register
  rpr_adc_seq #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_adc_seq (
    .clk_i    (REF_CLK_I),
    .rstn_i   (RSTN_I),
    .preset_i (preset),
    .trig_i   (cmd_adc_trig),
    .data_i   (ADC_DATA_I),
    .result_o (adc_result),
    .busy_o   (ADC_BUSY_O),
    .start_o  (ADC_START_O)
  );

  // registered read port, one cycle after the read strobe
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      REG_RDATA_O  <= 24'h000000;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
      if (REG_RD_I) begin
        REG_RDATA_O <= rd_mux;
      end
    end
  end

endmodule : rpr_regs

// ==== tb/rpr_regs_assertions.sv ====
/*
  Checker for the register bank: timing relations seen at the top ports.
  Assumes it is bound into rpr_regs with the same CONV_CYCLES.
*/
module rpr_regs_chk
  import rpr_pkg::*;
#(
  parameter int CONV_CYCLES = ADC_CONV_CYCLES
) (
  input wire logic        REF_CLK_I,
  input wire logic        RSTN_I,
  input wire logic        EN_I,
  input wire logic [5:0]  REG_ADDR_I,
  input wire logic [23:0] REG_WDATA_I,
  input wire logic        REG_WR_I,
  input wire logic        REG_RD_I,
  input wire logic        REG_RVALID_O,
  input wire logic [7:0]  CMD_I,
  input wire logic        CMD_STB_I,
  input wire logic        ADC_START_O,
  input wire logic        ADC_BUSY_O,
  input wire logic        RX_END_I,
  input wire logic [9:0]  RX_LEN_O,
  input wire logic        RX_SKIP_CRC_O,
  input wire logic        RX_RAW_FIFO_O,
  input wire logic        IRQ_HDR_IS_2ND_BYTE_O,
  input wire logic        THIRD_ERROR_IRQ_IS_RX_DONE_O,
  input wire logic [9:0]  SYNTH_B_O,
  input wire logic [9:0]  SYNTH_A_O,
  input wire logic [16:0] SYNTH_N_O,
  input wire logic        SYNTH_LOAD_O,
  input wire logic        PA_BIAS_DOUBLE_O,
  input wire logic        PA_BIAS_QUAD_O,
  input wire logic        VCO_DIRECT_O,
  input wire logic        EXT_RF_SELECT_O,
  input wire logic        PRESC_EN_O,
  input wire logic [7:0]  DAC_VALUE_O
);
  timeunit 1ns;
  timeprecision 100ps;
  // busy is seen high from the edge after the trigger up to the capture edge
  localparam int BUSY_LEN = CONV_CYCLES - 1;
  logic [15:0] busy_cnt;

  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);

  // a counter, since the full conversion is far too long to unroll
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) busy_cnt <= '0;
    else if (!ADC_BUSY_O) busy_cnt <= '0;
    else if (ADC_START_O) busy_cnt <= 16'h0001; // a retrigger restarts the count
    else busy_cnt <= busy_cnt + 16'h0001;
  end

  rvalid_pulse_a: assert property (
    REG_RVALID_O == $past(REG_RD_I)) else $error("read valid misplaced");
  adc_start_a: assert property (
    CMD_STB_I && EN_I && CMD_I == CMD_ADC_TRIG |=> ADC_START_O && ADC_BUSY_O)
    else $error("conversion did not start");
  busy_len_a: assert property (
    $fell(ADC_BUSY_O) |-> busy_cnt == BUSY_LEN) else $error("conversion length wrong");
  busy_bound_a: assert property (
    busy_cnt <= BUSY_LEN) else $error("conversion overran");
  hop_load_a: assert property (
    CMD_STB_I && EN_I && (CMD_I == CMD_HOP_MAIN || CMD_I == CMD_HOP_AUX)
    |=> SYNTH_LOAD_O) else $error("hop did not load");
  synth_n_a: assert property (
    SYNTH_N_O == {2'h0, SYNTH_B_O, 5'h00} + {2'h0, SYNTH_A_O, 5'h00} + {7'h00, SYNTH_A_O})
    else $error("division total wrong");
  irq_mode_a: assert property (
    IRQ_HDR_IS_2ND_BYTE_O == RX_RAW_FIFO_O && THIRD_ERROR_IRQ_IS_RX_DONE_O == RX_RAW_FIFO_O)
    else $error("irq remap wrong");
  rx_clear_a: assert property (
    RX_END_I && !REG_WR_I |-> ##2 RX_LEN_O == 10'h000 && !RX_SKIP_CRC_O && !RX_RAW_FIFO_O)
    else $error("rx length not cleared");
  en_preset_a: assert property (
    !EN_I |-> ##2 !PRESC_EN_O && !PA_BIAS_DOUBLE_O && DAC_VALUE_O == 8'h00)
    else $error("chip disable preset missing");
  main_bias_a: assert property (
    REG_WR_I && EN_I && REG_ADDR_I == ADDR_PLL_MAIN
    |-> ##2 PA_BIAS_DOUBLE_O == $past(REG_WDATA_I[23], 2)) else $error("bias double wrong");
  aux_bits_a: assert property (
    REG_WR_I && EN_I && REG_ADDR_I == ADDR_PLL_AUX
    |-> ##2 {PA_BIAS_QUAD_O, VCO_DIRECT_O, EXT_RF_SELECT_O, PRESC_EN_O}
    == $past(REG_WDATA_I[23:20], 2)) else $error("aux option bits wrong");

  conv_done_c: cover property ($fell(ADC_BUSY_O));
  hop_c: cover property (SYNTH_LOAD_O);
  rx_end_c: cover property (RX_END_I);
endmodule : rpr_regs_chk

bind rpr_regs rpr_regs_chk #(.CONV_CYCLES(CONV_CYCLES)) chk (.*);

// ==== tb/rpr_host_model.sv ====
/*
  Host model: drives the register port and the command strobe of the bank.
  Assumes the same clock as the bank; a released port shows inverted data.
*/
module rpr_host_model
  import rpr_pkg::*;
#(
  parameter int CONV = 8
) (
  input  wire logic        clk_i,
  output logic      [5:0]  addr_o,
  output logic      [23:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic      [7:0]  cmd_o,
  output logic             stb_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {addr_o, wdata_o, wr_o, rd_o, cmd_o, stb_o} = '0;
  end

  // one strobe per access, qualifiers held through the taking edge
  task automatic put(input logic [5:0] a, input logic [23:0] d, input logic w);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d; // no stale value left on a released port
  endtask : put

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    put(a, d, 1'b1);
  endtask : wr

  task automatic rd(input logic [5:0] a);
    put(a, 24'h000000, 1'b0);
  endtask : rd

  task automatic cmd(input logic [7:0] c);
    @(posedge clk_i);
    #1;
    cmd_o = c;
    stb_o = 1'b1;
    @(posedge clk_i);
    #1;
    stb_o = 1'b0;
    cmd_o = ~c;
  endtask : cmd

  // result is only read after the whole conversion time
  task automatic conv_wait();
    repeat (CONV) @(posedge clk_i);
  endtask : conv_wait
endmodule : rpr_host_model

// ==== tb/tb_top.sv ====
/*
  Self-checking bench for the register bank: host model on the register and
  command ports, bench drives chip enable, converter and receiver pins.
  Assumes the checker is bound in by its own file.
*/
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
  $display("Error %s expected %h seen %h", nm, e, s); end end
module tb_top
  import rpr_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CONV = 8;
  logic        clk, rstn, en, wr, rd, stb, rvalid, start, busy, rxs, rxe;
  logic        skip, raw, hdr, err3, load, pd, pq, vd, ext, presc;
  logic [5:0]  addr;
  logic [23:0] wdata, rdata, v, e;
  logic [7:0]  cmd, adc_d, dacv;
  logic [2:0]  msel, mselo, refs;
  logic [9:0]  rxlen, refk, sb, sa;
  logic [16:0] sn;
  logic [23:0] q[$];
  logic [9:0]  khz[8] = '{10'h1F4, 10'h0FA, 10'h07D, 10'h000, 10'h0C8, 10'h064, 10'h032,
                          10'h019};
  int          failures = 0;
  int          compares = 0;

  rpr_regs #(.CONV_CYCLES(CONV)) dut (
    .REF_CLK_I(clk), .RSTN_I(rstn), .EN_I(en), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .CMD_I(cmd), .CMD_STB_I(stb), .ADC_MSEL_I(msel),
    .ADC_DATA_I(adc_d), .ADC_MSEL_O(mselo), .ADC_START_O(start), .ADC_BUSY_O(busy),
    .RX_START_I(rxs), .RX_END_I(rxe), .RX_SKIP_CRC_O(skip), .RX_RAW_FIFO_O(raw),
    .IRQ_HDR_IS_2ND_BYTE_O(hdr), .THIRD_ERROR_IRQ_IS_RX_DONE_O(err3), .RX_LEN_O(rxlen),
    .PLL_REF_SELECT_O(refs), .PLL_REF_KHZ_O(refk), .SYNTH_B_O(sb), .SYNTH_A_O(sa),
    .SYNTH_N_O(sn), .SYNTH_LOAD_O(load), .PA_BIAS_DOUBLE_O(pd), .PA_BIAS_QUAD_O(pq),
    .VCO_DIRECT_O(vd), .EXT_RF_SELECT_O(ext), .PRESC_EN_O(presc), .DAC_VALUE_O(dacv));
  rpr_host_model #(.CONV(CONV)) host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .cmd_o(cmd), .stb_o(stb));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run();
    if (q.size() != 0) begin
      failures++;
      $display("Error read_queue expected 0 seen %0d", q.size());
    end
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // note the expected answer, then issue the read
  task automatic rexp(input logic [5:0] a, input logic [23:0] d);
    q.push_back(d);
    host.rd(a);
  endtask : rexp

  // outputs follow a write two edges later
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // each read answer retires the oldest note; looked at mid-cycle, where it has settled
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      if (q.size() == 0) begin
        failures++;
        $display("Error read_data expected none seen %h", rdata);
      end else begin
        e = q.pop_front();
        `CHK("read_data", e, rdata)
      end
    end
  end

  initial begin
    #100us;
    failures++;
    complete_run();
  end

  initial begin
    rstn = 1'b0;
    en = 1'b1;
    msel = 3'h0;
    adc_d = 8'h00;
    rxs = 1'b0;
    rxe = 1'b0;
    void'($urandom(45187));
    repeat (16) @(posedge clk);
    #1 rstn = 1'b1;
    `CHK("synth_n", 17'h10EF, sn)
    `CHK("ref_khz", 10'h0C8, refk)
    rexp(ADDR_PLL_MAIN, 24'h40D84F);
    rexp(ADDR_PLL_AUX, 24'h011846);
    rexp(ADDR_DAC, 24'h000000);
    rexp(ADDR_ADC_RESULT, 24'h000000);
    rexp(ADDR_RX_LEN_HI, 24'h000000);
    rexp(ADDR_RX_LEN_LO, 24'h000000);
    rexp(6'h20, 24'h000000);
    // every reference code, with random dividers, then a hop
    for (int c = 0; c < 8; c++) begin
      v = {1'($urandom), 3'(c), 20'($urandom)};
      host.wr(ADDR_PLL_MAIN, v);
      host.cmd(CMD_HOP_MAIN);
      settle();
      `CHK("ref_sel", v[22:20], refs)
      `CHK("ref_khz", khz[c], refk)
      `CHK("bias2", v[23], pd)
      `CHK("synth_ba", v[19:0], {sb, sa})
      `CHK("synth_n", 17'(v[19:10]) * 17'h20 + 17'(v[9:0]) * 17'h21, sn)
    end
    v = 24'($urandom);
    host.wr(ADDR_PLL_AUX, v);
    rexp(ADDR_PLL_AUX, v);
    host.cmd(CMD_HOP_AUX);
    settle();
    `CHK("aux_bits", v[23:20], {pq, vd, ext, presc})
    `CHK("synth_ba", v[19:0], {sb, sa})
    // chip disable presets the bank
    v = 24'($urandom) | 24'h000001;
    host.wr(ADDR_DAC, v);
    settle();
    `CHK("dac", v[7:0], dacv)
    rexp(ADDR_DAC, {16'h0000, v[7:0]});
    @(posedge clk);
    #1 en = 1'b0;
    @(posedge clk);
    #1 en = 1'b1;
    settle();
    `CHK("dac", 8'h00, dacv)
    rexp(ADDR_PLL_MAIN, 24'h40D84F);
    rexp(ADDR_PLL_AUX, 24'h011846);
    // conversion with a write to the readout place in mid-run
    msel = 3'($urandom);
    adc_d = 8'($urandom);
    host.cmd(CMD_ADC_TRIG);
    host.wr(ADDR_ADC_RESULT, {16'h0000, ~adc_d});
    host.conv_wait();
    `CHK("msel", msel, mselo)
    rexp(ADDR_ADC_RESULT, {16'h0000, adc_d});
    adc_d = ~adc_d;
    rexp(ADDR_ADC_RESULT, {16'h0000, ~adc_d});
    // receive options lapse at the end of one reception
    v = 24'($urandom);
    host.wr(ADDR_RX_LEN_HI, v | 24'h0000C0);
    host.wr(ADDR_RX_LEN_LO, v);
    settle();
    `CHK("rx_len", {v[1:0], v[7:0]}, rxlen)
    `CHK("rx_opts", 4'hF, {skip, raw, hdr, err3})
    rexp(ADDR_RX_LEN_HI, {16'h0000, v[7:0] & 8'hC3 | 8'hC0});
    @(posedge clk);
    #1 rxs = 1'b1;
    @(posedge clk);
    #1 rxs = 1'b0;
    rxe = 1'b1;
    @(posedge clk);
    #1 rxe = 1'b0;
    settle();
    `CHK("rx_opts", 4'h0, {skip, raw, hdr, err3})
    `CHK("rx_len", 10'h000, rxlen)
    rexp(ADDR_RX_LEN_HI, 24'h000000);
    rexp(ADDR_RX_LEN_LO, 24'h000000);
    repeat (4) @(posedge clk);
    complete_run();
  end
endmodule : tb_top
